// *** src/tvc_enable_defines.svh ***
// constants for the thrust vector control enable logic
`ifndef TVC_ENABLE_DEFINES_SVH
`define TVC_ENABLE_DEFINES_SVH

// register byte offsets
`define TVC_CTRL_OFS 32'h0000_0000
`define TVC_STATUS_OFS 32'h0000_0004

// control register fields and reset value
`define TVC_CTRL_PREAIM_BIT 0
`define TVC_CTRL_POSTINS_BIT 1
`define TVC_CTRL_W 2
`define TVC_CTRL_RST 2'h0

// status register fields
`define TVC_ST_PWR_BIT 0
`define TVC_ST_PREINS_BIT 1
`define TVC_ST_POSTINS_BIT 2
`define TVC_ST_NORMAL_BIT 3
`define TVC_ST_GUIDE_BIT 4
`define TVC_ST_OUTEN_BIT 5
`define TVC_ST_ROLL_BIT 6
`define TVC_ST_GYRO_BIT 7
`define TVC_ST_PINS_LSB 8

// positions of the discrete pin inputs in the filter vector
`define TVC_PIN_PREPARE 0
`define TVC_PIN_BACKUP1 1
`define TVC_PIN_BURN 2
`define TVC_PIN_PYRO 3
`define TVC_PIN_SEQ_A 4
`define TVC_PIN_SEQ_B 5
`define TVC_PIN_DIRECT 6
`define TVC_PIN_GYRO 7
`define TVC_PIN_N 8

// timing: gyro spin-up delay in minutes and clock rate in hertz
`define TVC_GYRO_DELAY_MIN 3
`define TVC_CLK_HZ 10000000
`define TVC_CNT_W 31

`endif

// *** src/tvc_pkg.sv ***
// types for the thrust vector control enable logic
`include "tvc_enable_defines.svh"

package tvc_pkg;

   typedef struct packed {
      logic [`TVC_PIN_N-1:0] sync1;
      logic [`TVC_PIN_N-1:0] sync2;
      logic [`TVC_PIN_N-1:0] sync3;
      logic [`TVC_PIN_N-1:0] pins;
      logic [`TVC_CNT_W-1:0] gyro_cnt;
      logic gyro_power_delayed;
      logic roll_amp_enable;
      logic [`TVC_CTRL_W-1:0] ctrl;
      logic tvc_power_enable;
      logic preins_bias_sel;
      logic postins_bias_sel;
      logic normal_bias_sel;
      logic path_guidance_en;
      logic tvc_output_en;
      logic ap_write;
      logic [31:0] ap_addr;
      logic [31:0] rdata;
      logic ready_out;
   } tvc_state_t;

endpackage

// *** src/tvc_enable_logic.sv ***
// thrust vector control power, preaim bias, guidance and output enables with an ahb-lite register slave
`timescale 1ns/1ps
`include "tvc_enable_defines.svh"

module tvc_enable_logic
   import tvc_pkg::*;
#(
   parameter int unsigned GYRO_DELAY_CYC = `TVC_GYRO_DELAY_MIN * 60 * `TVC_CLK_HZ
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // discretes from sequencer, pyro switch and gyro supply
   input wire logic tvc_prepare_mode,
   input wire logic backup_mode_one,
   input wire logic motor_burn_mode,
   input wire logic pyro_arming_switch,
   input wire logic seq_backup_a,
   input wire logic seq_backup_b,
   input wire logic direct_backup_cmd,
   input wire logic gyro_power_on,
   // enables
   output logic tvc_power_enable,
   output logic preins_bias_sel,
   output logic postins_bias_sel,
   output logic normal_bias_sel,
   output logic path_guidance_en,
   output logic tvc_output_en,
   output logic roll_amp_enable,
   output logic gyro_power_delayed
);

   localparam logic [`TVC_CNT_W-1:0] DELAY_LAST = `TVC_CNT_W'(GYRO_DELAY_CYC - 1);

   tvc_state_t s_r;
   tvc_state_t s_nxt;
   logic [`TVC_PIN_N-1:0] pin_raw;
   logic [31:0] status_word;

   assign pin_raw[`TVC_PIN_PREPARE] = tvc_prepare_mode;
   assign pin_raw[`TVC_PIN_BACKUP1] = backup_mode_one;
   assign pin_raw[`TVC_PIN_BURN] = motor_burn_mode;
   assign pin_raw[`TVC_PIN_PYRO] = pyro_arming_switch;
   assign pin_raw[`TVC_PIN_SEQ_A] = seq_backup_a;
   assign pin_raw[`TVC_PIN_SEQ_B] = seq_backup_b;
   assign pin_raw[`TVC_PIN_DIRECT] = direct_backup_cmd;
   assign pin_raw[`TVC_PIN_GYRO] = gyro_power_on;

   assign status_word = {16'h0000, s_r.pins, s_r.gyro_power_delayed, s_r.roll_amp_enable, s_r.tvc_output_en,
                         s_r.path_guidance_en, s_r.normal_bias_sel, s_r.postins_bias_sel, s_r.preins_bias_sel,
                         s_r.tvc_power_enable};

   always_comb begin
      s_nxt = s_r;
      // three-stage synchroniser; a pin changes once stages two and three agree
      s_nxt.sync1 = pin_raw;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sync3 = s_r.sync2;
      s_nxt.pins = (s_r.sync2 & s_r.sync3) | (s_r.pins & (s_r.sync2 ^ s_r.sync3));

      // gyro spin-up delay; dropping gyro power restarts it
      if (!s_r.pins[`TVC_PIN_GYRO]) begin
         s_nxt.gyro_cnt = '0;
         s_nxt.gyro_power_delayed = 1'b0;
      end else if (s_r.gyro_cnt == DELAY_LAST) begin
         s_nxt.gyro_power_delayed = 1'b1;
      end else begin
         s_nxt.gyro_cnt = s_r.gyro_cnt + `TVC_CNT_W'(1);
      end

      // latch only: nothing short of reset turns the roll amplifier off again
      if (s_r.pins[`TVC_PIN_PYRO] || s_r.pins[`TVC_PIN_SEQ_A] || s_r.pins[`TVC_PIN_SEQ_B] ||
          s_r.pins[`TVC_PIN_BACKUP1] || s_r.pins[`TVC_PIN_DIRECT]) begin
         s_nxt.roll_amp_enable = 1'b1;
      end

      // single enable covers electronics and actuators
      s_nxt.tvc_power_enable = s_r.pins[`TVC_PIN_PREPARE] || s_r.pins[`TVC_PIN_BACKUP1] ||
                               (!s_r.roll_amp_enable && s_r.gyro_power_delayed);
      s_nxt.preins_bias_sel = s_r.ctrl[`TVC_CTRL_PREAIM_BIT] && !s_r.ctrl[`TVC_CTRL_POSTINS_BIT];
      s_nxt.postins_bias_sel = s_r.ctrl[`TVC_CTRL_PREAIM_BIT] && s_r.ctrl[`TVC_CTRL_POSTINS_BIT];
      s_nxt.normal_bias_sel = !s_r.ctrl[`TVC_CTRL_PREAIM_BIT];
      s_nxt.path_guidance_en = s_r.pins[`TVC_PIN_BURN];
      s_nxt.tvc_output_en = s_r.roll_amp_enable;

      // data phase of a write: only the control register takes data
      if (s_r.ap_write) begin
         if (s_r.ap_addr == `TVC_CTRL_OFS) begin
            s_nxt.ctrl = hwdata[`TVC_CTRL_W-1:0];
         end
      end

      // address phase; zero wait states so read data is ready for the data phase
      s_nxt.ap_write = 1'b0;
      if (hsel && htrans[1] && hready) begin
         s_nxt.ap_write = hwrite;
         s_nxt.ap_addr = haddr;
         if (haddr == `TVC_CTRL_OFS) begin
            // take the post-write value so a read right behind a write is not stale
            s_nxt.rdata = {30'h0, s_nxt.ctrl};
         end else if (haddr == `TVC_STATUS_OFS) begin
            s_nxt.rdata = status_word;
         end else begin
            s_nxt.rdata = 32'h0000_0000;
         end
      end
      s_nxt.ready_out = 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '{ctrl: `TVC_CTRL_RST, ready_out: 1'b1, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hreadyout = s_r.ready_out;
   assign hresp = 1'b0;
   assign hrdata = s_r.rdata;
   assign tvc_power_enable = s_r.tvc_power_enable;
   assign preins_bias_sel = s_r.preins_bias_sel;
   assign postins_bias_sel = s_r.postins_bias_sel;
   assign normal_bias_sel = s_r.normal_bias_sel;
   assign path_guidance_en = s_r.path_guidance_en;
   assign tvc_output_en = s_r.tvc_output_en;
   assign roll_amp_enable = s_r.roll_amp_enable;
   assign gyro_power_delayed = s_r.gyro_power_delayed;

   // checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   power_from_modes_a: assert property (
      ##1 (tvc_power_enable == $past(s_r.pins[`TVC_PIN_PREPARE] || s_r.pins[`TVC_PIN_BACKUP1] ||
                                     (!roll_amp_enable && gyro_power_delayed))))
      else $error("power enable does not follow mode terms");

   power_gated_gyro_a: assert property (
      (!s_r.pins[`TVC_PIN_PREPARE] && !s_r.pins[`TVC_PIN_BACKUP1] && !gyro_power_delayed) |=> !tvc_power_enable)
      else $error("power enable rose without delayed gyro power");

   preins_select_a: assert property (
      (s_r.ctrl == 2'h1) |=> preins_bias_sel && !postins_bias_sel && !normal_bias_sel)
      else $error("preinsertion bias not selected");

   postins_select_a: assert property (
      (s_r.ctrl == 2'h3) |=> postins_bias_sel && !preins_bias_sel && !normal_bias_sel)
      else $error("postinsertion bias not selected");

   normal_select_a: assert property (
      !s_r.ctrl[`TVC_CTRL_PREAIM_BIT] |=> normal_bias_sel && !preins_bias_sel && !postins_bias_sel)
      else $error("normal preaim bias not selected");

   guidance_follows_burn_a: assert property (
      ##1 (path_guidance_en == $past(s_r.pins[`TVC_PIN_BURN])))
      else $error("guidance enable does not follow burn mode");

   outputs_follow_roll_a: assert property (
      ##1 (tvc_output_en == $past(roll_amp_enable)))
      else $error("servo outputs do not follow roll amp");

   roll_amp_held_a: assert property (
      roll_amp_enable |=> roll_amp_enable)
      else $error("roll amp enable dropped");

   roll_amp_set_a: assert property (
      s_r.pins[`TVC_PIN_PYRO] |=> roll_amp_enable)
      else $error("pyro arming did not set roll amp enable");

   roll_amp_backup_a: assert property (
      (s_r.pins[`TVC_PIN_SEQ_A] || s_r.pins[`TVC_PIN_SEQ_B] || s_r.pins[`TVC_PIN_DIRECT] ||
       s_r.pins[`TVC_PIN_BACKUP1]) |=> roll_amp_enable)
      else $error("backup did not set roll amp enable");

   roll_amp_cause_a: assert property (
      $rose(roll_amp_enable) |-> $past(s_r.pins[`TVC_PIN_PYRO] || s_r.pins[`TVC_PIN_SEQ_A] ||
         s_r.pins[`TVC_PIN_SEQ_B] || s_r.pins[`TVC_PIN_BACKUP1] || s_r.pins[`TVC_PIN_DIRECT]))
      else $error("roll amp enable set without a cause");

   ctrl_write_a: assert property (
      (s_r.ap_write && s_r.ap_addr == `TVC_CTRL_OFS) |=> (s_r.ctrl == $past(hwdata[`TVC_CTRL_W-1:0])))
      else $error("control write did not land");

   gyro_delay_a: assert property (
      $rose(gyro_power_delayed) |-> $past(s_r.gyro_cnt) == DELAY_LAST && $past(s_r.pins[`TVC_PIN_GYRO]))
      else $error("delayed gyro power rose early");

   gyro_drop_a: assert property (
      !s_r.pins[`TVC_PIN_GYRO] |=> !gyro_power_delayed)
      else $error("delayed gyro power held without gyro power");

   gyro_count_a: assert property (
      gyro_power_delayed |-> (s_r.gyro_cnt == DELAY_LAST))
      else $error("delayed gyro power up before full count");

   launch_power_c: cover property (!roll_amp_enable && gyro_power_delayed ##1 tvc_power_enable);
   separation_c: cover property ($rose(roll_amp_enable) ##[1:20] $rose(tvc_output_en));
   burn_c: cover property (tvc_power_enable && path_guidance_en && tvc_output_en);
   postins_c: cover property ($rose(postins_bias_sel));
   gyro_delay_c: cover property ($rose(gyro_power_delayed));

endmodule

// *** verif/tvc_seq_model.sv ***
// discrete source standing in for the sequencer, pyro switch and gyro supply
`timescale 1ns/1ps
module tvc_seq_model (
   // clock and requested levels, bit order as the pin filter vector
   input wire logic hclk,
   input wire logic [7:0] req,
   // discretes
   output logic tvc_prepare_mode,
   output logic backup_mode_one,
   output logic motor_burn_mode,
   output logic pyro_arming_switch,
   output logic seq_backup_a,
   output logic seq_backup_b,
   output logic direct_backup_cmd,
   output logic gyro_power_on
);
   // levels move only just after an edge, as the real sequencer outputs do
   always_ff @(posedge hclk) begin
      {gyro_power_on, direct_backup_cmd, seq_backup_b, seq_backup_a, pyro_arming_switch, motor_burn_mode,
       backup_mode_one, tvc_prepare_mode} <= req;
   end
endmodule

// *** verif/tb_tvc_enable_logic.sv ***
// self-checking bench for the thrust vector control enable logic
`timescale 1ns/1ps
`include "tvc_enable_defines.svh"
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %0t %s", $time, m); end end
module tb_tvc_enable_logic import tvc_pkg::*;;
   // short gyro delay keeps the run brief; expectations derive from it
   localparam int unsigned DLY = 20;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   logic [7:0] req = 8'h00;
   wire hreadyout, hresp, p0, p1, p2, p3, p4, p5, p6, p7;
   wire [31:0] hrdata;
   wire pwr, pre, post, norm, guide, outen, roll, gyd;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;
   int src[5] = '{`TVC_PIN_PYRO, `TVC_PIN_SEQ_A, `TVC_PIN_SEQ_B, `TVC_PIN_DIRECT, `TVC_PIN_BACKUP1};
   always #50 hclk = ~hclk;
   tvc_seq_model u_tvc_seq_model (.hclk(hclk), .req(req), .tvc_prepare_mode(p0), .backup_mode_one(p1),
      .motor_burn_mode(p2), .pyro_arming_switch(p3), .seq_backup_a(p4), .seq_backup_b(p5),
      .direct_backup_cmd(p6), .gyro_power_on(p7));
   tvc_enable_logic #(.GYRO_DELAY_CYC(DLY)) u_tvc_enable_logic (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tvc_prepare_mode(p0), .backup_mode_one(p1),
      .motor_burn_mode(p2), .pyro_arming_switch(p3), .seq_backup_a(p4), .seq_backup_b(p5),
      .direct_backup_cmd(p6), .gyro_power_on(p7), .tvc_power_enable(pwr), .preins_bias_sel(pre),
      .postins_bias_sel(post), .normal_bias_sel(norm), .path_guidance_en(guide), .tvc_output_en(outen),
      .roll_amp_enable(roll), .gyro_power_delayed(gyd));
   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // cut a hang short; the whole run needs well under a thousand cycles
   always @(posedge hclk) begin
      cyc++;
      if (cyc > 3000) begin
         miscompares++;
         $display("MISMATCH %0t timeout", $time);
         finish_test();
      end
   end
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic pin(input int i, input logic v, input int n);
      @(posedge hclk);
      req[i] <= v;
      repeat (n) @(posedge hclk);
   endtask
   task automatic do_reset;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask
   task automatic t_reset;
      `CHK(norm, 1'b1, "normal bias")
      `CHK(pwr, 1'b0, "power at reset")
      `CHK(hresp, 1'b0, "okay response")
      bus(1'b0, `TVC_STATUS_OFS, 32'h0);
      `CHK(rd, 32'h0000_0008, "status")
      bus(1'b0, 32'h0000_0010, 32'h0);
      `CHK(rd, 32'h0, "unmapped")
      $display("done reset");
   endtask
   task automatic t_bias;
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, `TVC_CTRL_OFS, 32'(i));
         repeat (2) @(posedge hclk);
         `CHK(pre, logic'(i == 1), "preins")
         `CHK(post, logic'(i == 3), "postins")
         `CHK(norm, logic'(i % 2 == 0), "normal")
         bus(1'b0, `TVC_CTRL_OFS, 32'h0);
         `CHK(rd, 32'(i), "ctrl readback")
      end
      bus(1'b1, `TVC_STATUS_OFS, 32'h0);
      bus(1'b0, `TVC_CTRL_OFS, 32'h0);
      `CHK(rd, 32'h3, "status write ignored")
      $display("done bias");
   endtask
   task automatic t_modes;
      pin(`TVC_PIN_PREPARE, 1'b1, 8);
      `CHK(pwr, 1'b1, "prepare power")
      pin(`TVC_PIN_PREPARE, 1'b0, 8);
      `CHK(pwr, 1'b0, "prepare off")
      pin(`TVC_PIN_BURN, 1'b1, 8);
      `CHK(guide, 1'b1, "guidance on")
      pin(`TVC_PIN_BURN, 1'b0, 8);
      `CHK(guide, 1'b0, "guidance off")
      // delayed gyro term: filter 4 edges, then the delay plus one
      pin(`TVC_PIN_GYRO, 1'b1, DLY);
      `CHK(gyd, 1'b0, "gyro early")
      `CHK(pwr, 1'b0, "power early")
      repeat (10) @(posedge hclk);
      `CHK(gyd, 1'b1, "gyro delayed")
      `CHK(pwr, 1'b1, "launch power")
      $display("done modes");
   endtask
   task automatic t_roll;
      foreach (src[k]) begin
         do_reset();
         repeat (DLY + 10) @(posedge hclk);
         `CHK(outen, 1'b0, "outputs idle")
         pin(src[k], 1'b1, 10);
         `CHK(roll, 1'b1, "roll set")
         `CHK(outen, 1'b1, "outputs on")
         `CHK(pwr, logic'(src[k] == `TVC_PIN_BACKUP1), "power after roll")
         bus(1'b0, `TVC_STATUS_OFS, 32'h0);
         `CHK(rd, 32'h0000_80e8 | (32'h1 << (8 + src[k])) | 32'(src[k] == `TVC_PIN_BACKUP1), "status")
         pin(src[k], 1'b0, 10);
         `CHK(roll, 1'b1, "roll held")
      end
      $display("done roll");
   endtask
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_reset();
      t_bias();
      t_modes();
      t_roll();
      finish_test();
   end
endmodule
